// ==== core/audio_smi_status_tree.sv ====
// audio smi status hierarchy with fast-path legacy io handling
`timescale 1ns/1ps
// Operation
// - top status at 00h keeps bits on read, 02h clears them on read
// - source status readable at 10h (clearing) and 12h (non-clearing)
// - reading 10h returns source bits then clears them all
// - reading 12h returns source bits and changes nothing
// - bits 7..2 flag end-of-page smi from bus masters 5..0
// - a master's smi is armed by its enable and fires on eop rise
// - bit 1 flags codec serial (08h[23]) or gpio (00h[30]) smi
// - bit 0 flags io trap, details kept in register 14h
// - any source bit is summarised at top status bit 1
// - register 18h selects trapped ranges and fast-path enables
// - with 18h[4] set, covered status reads are answered, no smi
// - fast read covers 388h-38Bh and 2x0,1,2,3,8,9h
// - no read trapping unless sound-card or fm mapping is on
// - with 18h[11], first write of pair captured, no smi, a1 at 14h[15]
// - second write of the pair raises smi and is captured normally
// - fast write covers 388h, 38Ah, 38Bh and 2x0h, 2x2h, 2x8h
// - bits 15:8 of both source registers read as zero
module audio_smi_status_tree (
   input  wire logic                    CORE_CLK_I,
   input  wire logic                    NRST_I,
   input  wire audio_smi_pkg::reg_req_s REG_REQ_I,
   output logic [31:0]                  REG_RDATA_O,
   output logic                         REG_RVALID_O,
   input  wire logic [5:0]              BM_EOP_I,
   input  wire logic                    CODEC_SERIAL_INT_I,
   input  wire logic                    CODEC_GPIO_INT_I,
   input  wire audio_smi_pkg::io_req_s  IO_REQ_I,
   output logic                         IO_CLAIM_O,
   output logic [7:0]                   IO_RDATA_O,
   output logic                         IO_RVALID_O,
   output logic                         SMI_O
);
   localparam int NBM = audio_smi_pkg::NUM_BM;

   // register state
   logic [1:0]     gpio_ctl;
   logic           serial_smi_en;
   logic [31:0]    trap_en;
   logic [3:0]     sb_base;
   logic [NBM-1:0] bm_en;
   logic [NBM-1:0] eop_prev;
   logic [7:0]     src;
   logic           top_audio;
   logic [7:0]     even_data;
   logic [7:0]     odd_data;
   logic           fast_a1;
   logic           last_rw;
   logic           trap_flag;
   logic           index_pending;

   // decode results
   logic           fm_hit;
   logic           sb_hit;
   logic           fast_rd_addr;
   logic           fast_wr_addr;
   logic [3:0]     slot;
   logic           map_hit;
   logic           io_rd;
   logic           io_wr;
   logic           fast_read;
   logic           fast_first;
   logic           trapped;
   logic [7:0]     src_set;
   logic [7:0]     next_src;
   logic           src_clear_rd;
   logic           top_clear_rd;
   logic [NBM-1:0] eop_rise;
   logic           mem_wr;
   logic [31:0]    next_rdata;

   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] ofs,
                                input logic       pwr,
                                input logic       want_pwr);
      hit = (a == ofs) && (pwr == want_pwr);
   endfunction

   function automatic logic [7:0] bm_ofs(input int n);
      bm_ofs = audio_smi_pkg::OFS_BM_CTRL0
               + 8'(n) * audio_smi_pkg::BM_STRIDE;
   endfunction

   legacy_io_decode u_decode (
      .addr_i    (IO_REQ_I.addr),
      .sb_base_i (sb_base),
      .fm_hit_o  (fm_hit),
      .sb_hit_o  (sb_hit),
      .fast_rd_o (fast_rd_addr),
      .fast_wr_o (fast_wr_addr),
      .slot_o    (slot)
   );

   assign mem_wr = REG_REQ_I.wr && !REG_REQ_I.power
                   && REG_REQ_I.addr[7:4] == audio_smi_pkg::OFS_FAST_MEM[7:4];

   fast_read_store #(
      .WIDTH (8),
      .DEPTH (16),
      .AW    (4)
   ) u_store (
      .clk_i   (CORE_CLK_I),
      .wr_i    (mem_wr),
      .waddr_i (REG_REQ_I.addr[3:0]),
      .wdata_i (REG_REQ_I.wdata[7:0]),
      .raddr_i (slot),
      .rdata_o (IO_RDATA_O)
   );

   // legacy io classification
   always_comb begin
      // mapping gates every trap, reads included
      map_hit = (fm_hit && trap_en[audio_smi_pkg::FM_MAP_BIT])
                || (sb_hit && trap_en[audio_smi_pkg::SB_MAP_BIT]);
      io_rd = IO_REQ_I.valid && !IO_REQ_I.write && map_hit;
      io_wr = IO_REQ_I.valid && IO_REQ_I.write && map_hit;
      fast_read = io_rd && fast_rd_addr
                  && trap_en[audio_smi_pkg::FAST_RD_BIT];
      fast_first = io_wr && fast_wr_addr && !index_pending
                   && trap_en[audio_smi_pkg::FAST_WR_BIT];
      trapped = (io_rd && !fast_read) || (io_wr && !fast_first);
   end

   assign IO_CLAIM_O = fast_read;

   always_ff @(posedge CORE_CLK_I) begin
      if (!NRST_I) begin
         IO_RVALID_O <= 1'b0;
      end else begin
         IO_RVALID_O <= fast_read;
      end
   end

   // source events
   always_comb begin
      eop_rise = BM_EOP_I & ~eop_prev & bm_en;
      src_set = 8'h00;
      src_set[audio_smi_pkg::SRC_BM_LSB +: NBM] = eop_rise;
      src_set[audio_smi_pkg::SRC_CODEC_BIT] =
         (CODEC_SERIAL_INT_I && serial_smi_en)
         || (CODEC_GPIO_INT_I && gpio_ctl[0]);
      src_set[audio_smi_pkg::SRC_TRAP_BIT] = trapped;
      src_clear_rd = REG_REQ_I.rd && hit(REG_REQ_I.addr,
                     audio_smi_pkg::OFS_SRC_CLEAR, REG_REQ_I.power, 1'b0);
      top_clear_rd = REG_REQ_I.rd && hit(REG_REQ_I.addr,
                     audio_smi_pkg::OFS_TOP_CLEAR, REG_REQ_I.power, 1'b1);
      // a new event in the clearing cycle survives the clear
      next_src = (src & ~{8{src_clear_rd}}) | src_set;
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!NRST_I) begin
         eop_prev <= '0;
      end else begin
         eop_prev <= BM_EOP_I;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!NRST_I) begin
         src <= audio_smi_pkg::SRC_RESET[7:0];
      end else begin
         src <= next_src;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!NRST_I) begin
         top_audio <= 1'b0;
      end else begin
         top_audio <= (top_audio && !top_clear_rd)
                      || (|next_src);
      end
   end

   assign SMI_O = |src;

   // io trap capture
   always_ff @(posedge CORE_CLK_I) begin
      if (!NRST_I) begin
         index_pending <= 1'b0;
         fast_a1       <= 1'b0;
         even_data     <= 8'h00;
         odd_data      <= 8'h00;
         last_rw       <= 1'b0;
         trap_flag     <= 1'b0;
      end else begin
         if (fast_first) begin
            index_pending <= 1'b1;
            fast_a1       <= IO_REQ_I.addr[1];
            if (IO_REQ_I.addr[0]) begin
               odd_data  <= IO_REQ_I.data;
            end else begin
               even_data <= IO_REQ_I.data;
            end
         end else if (trapped) begin
            index_pending <= 1'b0;
            last_rw       <= IO_REQ_I.write;
            if (IO_REQ_I.write) begin
               odd_data <= IO_REQ_I.data;
            end
         end
         if (trapped) begin
            trap_flag <= 1'b1;
         end else if (src_clear_rd) begin
            trap_flag <= 1'b0;
         end
      end
   end

   // software-written configuration
   always_ff @(posedge CORE_CLK_I) begin
      if (!NRST_I) begin
         gpio_ctl      <= 2'h0;
         serial_smi_en <= 1'b0;
         trap_en       <= audio_smi_pkg::WORD_RESET;
         sb_base       <= audio_smi_pkg::SB_BASE_RESET;
      end else if (REG_REQ_I.wr && !REG_REQ_I.power) begin
         unique case (REG_REQ_I.addr)
            audio_smi_pkg::OFS_GPIO_STAT: begin
               gpio_ctl <= REG_REQ_I.wdata[31:30];
            end
            audio_smi_pkg::OFS_CODEC_STAT: begin
               serial_smi_en <=
                  REG_REQ_I.wdata[audio_smi_pkg::SERIAL_SMI_EN_BIT];
            end
            audio_smi_pkg::OFS_TRAP_EN: begin
               trap_en <= REG_REQ_I.wdata;
            end
            audio_smi_pkg::OFS_SB_BASE: begin
               sb_base <= REG_REQ_I.wdata[3:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!NRST_I) begin
         bm_en <= '0;
      end else if (REG_REQ_I.wr && !REG_REQ_I.power) begin
         for (int n = 0; n < NBM; n++) begin
            if (REG_REQ_I.addr == bm_ofs(n)) begin
               bm_en[n] <= REG_REQ_I.wdata[0];
            end
         end
      end
   end

   // read mux; unmapped offsets read as zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (REG_REQ_I.power) begin
         if (REG_REQ_I.addr == audio_smi_pkg::OFS_TOP_MIRROR
             || REG_REQ_I.addr == audio_smi_pkg::OFS_TOP_CLEAR) begin
            next_rdata[audio_smi_pkg::TOP_AUDIO_BIT] = top_audio;
         end
      end else begin
         unique case (REG_REQ_I.addr)
            audio_smi_pkg::OFS_GPIO_STAT: begin
               next_rdata[31:30] = gpio_ctl;
            end
            audio_smi_pkg::OFS_CODEC_STAT: begin
               next_rdata[audio_smi_pkg::SERIAL_SMI_EN_BIT] = serial_smi_en;
            end
            audio_smi_pkg::OFS_SRC_CLEAR,
            audio_smi_pkg::OFS_SRC_SHADOW: begin
               next_rdata[7:0] = src;
            end
            audio_smi_pkg::OFS_TRAP_STAT: begin
               next_rdata[audio_smi_pkg::EVEN_LSB +: 8] = even_data;
               next_rdata[audio_smi_pkg::ODD_LSB +: 8]  = odd_data;
               next_rdata[audio_smi_pkg::A1_BIT]        = fast_a1;
               next_rdata[audio_smi_pkg::RW_BIT]        = last_rw;
               next_rdata[audio_smi_pkg::TRAP_FLAG_BIT] = trap_flag;
            end
            audio_smi_pkg::OFS_TRAP_EN: begin
               next_rdata = trap_en;
            end
            audio_smi_pkg::OFS_SB_BASE: begin
               next_rdata[3:0] = sb_base;
            end
            default: begin
               for (int n = 0; n < NBM; n++) begin
                  if (REG_REQ_I.addr == bm_ofs(n)) begin
                     next_rdata[0] = bm_en[n];
                     next_rdata[audio_smi_pkg::BM_EOP_BIT] = BM_EOP_I[n];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!NRST_I) begin
         REG_RDATA_O  <= audio_smi_pkg::WORD_RESET;
         REG_RVALID_O <= 1'b0;
      end else begin
         REG_RDATA_O  <= REG_REQ_I.rd ? next_rdata : REG_RDATA_O;
         REG_RVALID_O <= REG_REQ_I.rd;
      end
   end

   // checks
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!NRST_I);

   a_clear_read_empties: assert property (
      src_clear_rd && src_set == 8'h00 |=> src == 8'h00)
      else $error("clearing read left source bits set");
   a_shadow_read_keeps: assert property (
      REG_REQ_I.rd && !REG_REQ_I.power
      && REG_REQ_I.addr == audio_smi_pkg::OFS_SRC_SHADOW
      |=> src == ($past(src) | $past(src_set)))
      else $error("shadow read altered source bits");
   a_eop_sets_bit: assert property (
      eop_rise[0] |=> src[audio_smi_pkg::SRC_BM_LSB])
      else $error("eop of master 0 not flagged");
   a_disarmed_master: assert property (
      !bm_en[5] && !src[7] |=> !src[7])
      else $error("disarmed master raised smi");
   a_smi_follows_src: assert property (
      src_clear_rd && src_set == 8'h00 |=> !SMI_O)
      else $error("smi stayed high after clear");
   a_upper_zero: assert property (
      $past(src_clear_rd) |-> REG_RDATA_O[15:8] == 8'h00 && REG_RVALID_O)
      else $error("reserved source bits nonzero");
   a_fast_read_quiet: assert property (
      fast_read && !src[0] |=> IO_RVALID_O && !src[0])
      else $error("fast read raised trap or gave no data");
   a_no_map_no_trap: assert property (
      IO_REQ_I.valid && !map_hit && !src[0] |=> !src[0] && !IO_RVALID_O)
      else $error("unmapped access was trapped");
   a_first_write_quiet: assert property (
      fast_first |=> fast_a1 == $past(IO_REQ_I.addr[1]) && index_pending
      && src[0] == $past(src[0] && !src_clear_rd))
      else $error("first fast write mishandled");
   a_second_write_smi: assert property (
      index_pending && io_wr ##1 !src_clear_rd |-> src[0] && !index_pending)
      else $error("second write did not raise smi");
   a_top_summary: assert property (
      |src |-> top_audio)
      else $error("top summary missing");

   c_eop_smi:  cover property (eop_rise != '0 ##1 SMI_O);
   c_fast_rd:  cover property (fast_read ##1 IO_RVALID_O);
   c_pair:     cover property (fast_first ##[1:20] trapped);
   c_clear:    cover property (SMI_O ##1 src_clear_rd ##1 !SMI_O);
endmodule

// ==== core/audio_smi_pkg.sv ====
// constants and carrier types for the audio smi status tree
package audio_smi_pkg;
   // register offsets, audio function space
   localparam logic [7:0] OFS_GPIO_STAT   = 8'h00;
   localparam logic [7:0] OFS_CODEC_STAT  = 8'h08;
   localparam logic [7:0] OFS_SRC_CLEAR   = 8'h10;
   localparam logic [7:0] OFS_SRC_SHADOW  = 8'h12;
   localparam logic [7:0] OFS_TRAP_STAT   = 8'h14;
   localparam logic [7:0] OFS_TRAP_EN     = 8'h18;
   localparam logic [7:0] OFS_SB_BASE     = 8'h1c;
   localparam logic [7:0] OFS_BM_CTRL0    = 8'h20;
   localparam logic [7:0] BM_STRIDE       = 8'h08;
   localparam logic [7:0] OFS_FAST_MEM    = 8'h60;
   // register offsets, power function space
   localparam logic [7:0] OFS_TOP_MIRROR  = 8'h00;
   localparam logic [7:0] OFS_TOP_CLEAR   = 8'h02;
   // field positions
   localparam int GPIO_IF_EN_BIT    = 31;
   localparam int GPIO_SMI_EN_BIT   = 30;
   localparam int SERIAL_SMI_EN_BIT = 23;
   localparam int FM_MAP_BIT        = 0;
   localparam int SB_MAP_BIT        = 1;
   localparam int FAST_RD_BIT       = 4;
   localparam int FAST_WR_BIT       = 11;
   localparam int TOP_AUDIO_BIT     = 1;
   localparam int SRC_TRAP_BIT      = 0;
   localparam int SRC_CODEC_BIT     = 1;
   localparam int SRC_BM_LSB        = 2;
   localparam int TRAP_FLAG_BIT     = 0;
   localparam int RW_BIT            = 14;
   localparam int A1_BIT            = 15;
   localparam int ODD_LSB           = 16;
   localparam int EVEN_LSB          = 24;
   localparam int BM_EOP_BIT        = 8;
   localparam int NUM_BM            = 6;
   // reset values
   localparam logic [15:0] SRC_RESET     = 16'h0000;
   localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
   localparam logic [3:0]  SB_BASE_RESET = 4'h2;
   // legacy io map
   localparam logic [9:0] FM_BASE  = 10'h388;
   localparam logic [9:0] SB_FRAME = 10'h200;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [9:0] addr;
      logic [7:0] data;
   } io_req_s;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic       power;
      logic [7:0] addr;
      logic [31:0] wdata;
   } reg_req_s;
endpackage

// ==== core/fast_read_store.sv ====
// small register file holding fast-path read answers
`timescale 1ns/1ps
module fast_read_store #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   input  wire logic             clk_i,
   input  wire logic             wr_i,
   input  wire logic [AW-1:0]    waddr_i,
   input  wire logic [WIDTH-1:0] wdata_i,
   input  wire logic [AW-1:0]    raddr_i,
   output logic      [WIDTH-1:0] rdata_o
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk_i) begin
      if (wr_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      rdata_o <= mem[raddr_i];
   end
endmodule

// ==== core/legacy_io_decode.sv ====
// classifies legacy sound-card and fm io addresses
`timescale 1ns/1ps
module legacy_io_decode (
   input  wire logic [9:0] addr_i,
   input  wire logic [3:0] sb_base_i,
   output logic            fm_hit_o,
   output logic            sb_hit_o,
   output logic            fast_rd_o,
   output logic            fast_wr_o,
   output logic [3:0]      slot_o
);
   logic [3:0] low;

   always_comb begin
      low      = addr_i[3:0];
      fm_hit_o = (addr_i[9:2] == audio_smi_pkg::FM_BASE[9:2]);
      sb_hit_o = (addr_i[9:8] == audio_smi_pkg::SB_FRAME[9:8])
                 && (addr_i[7:4] == sb_base_i);
      fast_rd_o = fm_hit_o
                  || (sb_hit_o && (low <= 4'h3 || low == 4'h8
                                   || low == 4'h9));
      fast_wr_o = (fm_hit_o && addr_i[1:0] != 2'h1)
                  || (sb_hit_o && (low == 4'h0 || low == 4'h2
                                   || low == 4'h8));
      // fm bytes in slots 0..3, fast-read sound-card bytes in 4..9
      if (fm_hit_o) begin
         slot_o = {2'h0, addr_i[1:0]};
      end else if (low <= 4'h3) begin
         slot_o = low + 4'h4;
      end else begin
         slot_o = low;
      end
   end
endmodule

// ==== verif/smm_host_model.sv ====
// host-side register access model for the audio smi status tree
`timescale 1ns/1ps
module smm_host_model (
   input  wire logic              clk_i,
   output audio_smi_pkg::reg_req_s req_o,
   input  wire logic [31:0]       rdata_i,
   input  wire logic              rvalid_i
);
   initial req_o = '0;

   // strobes last one cycle and change only at the falling edge
   task automatic wr(input logic pwr, input logic [7:0] ofs,
                     input logic [31:0] dat);
      @(negedge clk_i);
      req_o = '{rd: 1'b0, wr: 1'b1, power: pwr, addr: ofs, wdata: dat};
      @(negedge clk_i);
      req_o.wr = 1'b0;
   endtask

   // answer registers on the rise that samples the strobe, taken at the next fall
   task automatic rd(input logic pwr, input logic [7:0] ofs,
                     output logic [31:0] dat, output logic vld);
      @(negedge clk_i);
      req_o = '{rd: 1'b1, wr: 1'b0, power: pwr, addr: ofs, wdata: 32'h0};
      @(negedge clk_i);
      req_o.rd = 1'b0;
      vld = rvalid_i;
      dat = rdata_i;
   endtask
endmodule

// ==== verif/test_audio_smi_status_tree.sv ====
// self-checking bench for the audio smi status tree
`timescale 1ns/1ps
module test_audio_smi_status_tree;
   logic                    clk;
   logic                    nrst;
   audio_smi_pkg::reg_req_s req;
   audio_smi_pkg::io_req_s  io;
   logic [31:0]             rdata;
   logic                    rvalid;
   logic [5:0]              eop;
   logic                    ser_int;
   logic                    gpio_int;
   logic                    claim;
   logic [7:0]              io_rdata;
   logic                    io_rvalid;
   logic                    smi;
   int                      error_cnt = 0;
   int                      checks = 0;
   int                      cycles = 0;
   logic [31:0]             d;
   logic                    v;
   logic                    c;
   logic                    rv;
   logic [7:0]              b;
   logic [31:0]             e;
   logic [7:0]              ctl;
   logic [9:0]              a;
   // covered fast-read addresses, listed in memory slot order
   logic [9:0]              fa [10] = '{10'h388, 10'h389, 10'h38a, 10'h38b,
      10'h220, 10'h221, 10'h222, 10'h223, 10'h228, 10'h229};
   int                      fw [6] = '{0, 2, 3, 4, 6, 8};

   audio_smi_status_tree uut (
      .CORE_CLK_I         (clk),
      .NRST_I             (nrst),
      .REG_REQ_I          (req),
      .REG_RDATA_O        (rdata),
      .REG_RVALID_O       (rvalid),
      .BM_EOP_I           (eop),
      .CODEC_SERIAL_INT_I (ser_int),
      .CODEC_GPIO_INT_I   (gpio_int),
      .IO_REQ_I           (io),
      .IO_CLAIM_O         (claim),
      .IO_RDATA_O         (io_rdata),
      .IO_RVALID_O        (io_rvalid),
      .SMI_O              (smi)
   );

   smm_host_model host (
      .clk_i    (clk),
      .req_o    (req),
      .rdata_i  (rdata),
      .rvalid_i (rvalid)
   );

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic rr(input logic p, input logic [7:0] ofs,
                     input logic [31:0] exp, input string nm);
      host.rd(p, ofs, d, v);
      check({nm, "_valid"}, {31'h0, v}, 32'h1);
      check(nm, d, exp);
   endtask

   task automatic io_acc(input logic w, input logic [9:0] ad,
                         input logic [7:0] dat);
      @(negedge clk);
      io = '{valid: 1'b1, write: w, addr: ad, data: dat};
      // claim is combinational inside the request cycle
      #1 c = claim;
      @(negedge clk);
      io.valid = 1'b0;
      rv = io_rvalid;
      b = io_rdata;
   endtask

   task automatic pulse(input int n);
      @(negedge clk);
      if (n < 6) eop[n] = 1'b1;
      else if (n == 6) ser_int = 1'b1;
      else gpio_int = 1'b1;
      @(negedge clk);
      eop = 6'h00;
      ser_int = 1'b0;
      gpio_int = 1'b0;
   endtask

   // a hang is cut short well above the few hundred cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         error_cnt++;
         close_out();
      end
   end

   initial begin
      nrst = 1'b0;
      io = '0;
      eop = 6'h00;
      ser_int = 1'b0;
      gpio_int = 1'b0;
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      check("smi_reset", {31'h0, smi}, 32'h0);
      rr(1'b0, audio_smi_pkg::OFS_SRC_CLEAR, 32'h0, "clr_reset");
      rr(1'b0, audio_smi_pkg::OFS_SRC_SHADOW, 32'h0, "shd_reset");
      rr(1'b0, audio_smi_pkg::OFS_TRAP_STAT, 32'h0, "trap_reset");
      host.wr(1'b0, 8'h50, 32'hffff_ffff);
      rr(1'b0, 8'h50, 32'h0, "unmapped");
      pulse(0);
      rr(1'b0, audio_smi_pkg::OFS_SRC_SHADOW, 32'h0, "bm_off");
      for (int n = 0; n < 6; n++) begin
         ctl = 8'(audio_smi_pkg::OFS_BM_CTRL0 + audio_smi_pkg::BM_STRIDE * n);
         host.wr(1'b0, ctl, 32'h1);
         rr(1'b0, ctl, 32'h1, "bm_en");
         pulse(n);
         e = 32'h1 << (n + 2);
         rr(1'b0, audio_smi_pkg::OFS_SRC_SHADOW, e, "bm_shd");
         rr(1'b0, audio_smi_pkg::OFS_SRC_SHADOW, e, "bm_shd2");
         rr(1'b1, audio_smi_pkg::OFS_TOP_MIRROR, 32'h2, "top_bm");
         check("smi_bm", {31'h0, smi}, 32'h1);
         rr(1'b0, audio_smi_pkg::OFS_SRC_CLEAR, e, "bm_clr");
         rr(1'b0, audio_smi_pkg::OFS_SRC_SHADOW, 32'h0, "bm_gone");
         check("smi_off", {31'h0, smi}, 32'h0);
         if (n < 5) host.wr(1'b0, ctl, 32'h0);
      end
      pulse(5);
      rr(1'b1, audio_smi_pkg::OFS_TOP_MIRROR, 32'h2, "top_m1");
      rr(1'b1, audio_smi_pkg::OFS_TOP_MIRROR, 32'h2, "top_m2");
      rr(1'b0, audio_smi_pkg::OFS_SRC_CLEAR, 32'h80, "top_src");
      rr(1'b1, audio_smi_pkg::OFS_TOP_CLEAR, 32'h2, "top_c1");
      rr(1'b1, audio_smi_pkg::OFS_TOP_CLEAR, 32'h0, "top_c2");
      rr(1'b1, audio_smi_pkg::OFS_TOP_MIRROR, 32'h0, "top_m3");
      // codec interrupts count only once their own enable is set
      pulse(6);
      pulse(7);
      rr(1'b0, audio_smi_pkg::OFS_SRC_SHADOW, 32'h0, "codec_off");
      host.wr(1'b0, audio_smi_pkg::OFS_CODEC_STAT, 32'h0080_0000);
      pulse(6);
      rr(1'b0, audio_smi_pkg::OFS_SRC_CLEAR, 32'h2, "serial");
      host.wr(1'b0, audio_smi_pkg::OFS_CODEC_STAT, 32'h0);
      host.wr(1'b0, audio_smi_pkg::OFS_GPIO_STAT, 32'h4000_0000);
      pulse(7);
      rr(1'b0, audio_smi_pkg::OFS_SRC_CLEAR, 32'h2, "gpio");
      // fast read: both maps on, answers preloaded per slot
      host.wr(1'b0, audio_smi_pkg::OFS_TRAP_EN, 32'h13);
      rr(1'b0, audio_smi_pkg::OFS_TRAP_EN, 32'h13, "trap_en");
      for (int i = 0; i < 10; i++) begin
         host.wr(1'b0, 8'(audio_smi_pkg::OFS_FAST_MEM + i), 32'(8'ha0 + i));
      end
      for (int i = 0; i < 10; i++) begin
         io_acc(1'b0, fa[i], 8'h00);
         check("fr_claim", {31'h0, c}, 32'h1);
         check("fr_rvalid", {31'h0, rv}, 32'h1);
         check("fr_data", {24'h0, b}, 32'(8'ha0 + i));
      end
      // sound-card block moved to 230h: slot 4 answers there
      host.wr(1'b0, audio_smi_pkg::OFS_SB_BASE, 32'h3);
      rr(1'b0, audio_smi_pkg::OFS_SB_BASE, 32'h3, "sb_base");
      io_acc(1'b0, 10'h230, 8'h00);
      check("sb_moved", {31'h0, c}, 32'h1);
      check("sb_data", {24'h0, b}, 32'ha4);
      host.wr(1'b0, audio_smi_pkg::OFS_SB_BASE, 32'h2);
      rr(1'b0, audio_smi_pkg::OFS_SRC_SHADOW, 32'h0, "fr_nosmi");
      io_acc(1'b0, 10'h224, 8'h00);
      check("fr_outside", {31'h0, c}, 32'h0);
      rr(1'b0, audio_smi_pkg::OFS_SRC_CLEAR, 32'h1, "sb_trap");
      host.wr(1'b0, audio_smi_pkg::OFS_TRAP_EN, 32'h10);
      io_acc(1'b0, 10'h388, 8'h00);
      check("nomap_claim", {31'h0, c}, 32'h0);
      rr(1'b0, audio_smi_pkg::OFS_SRC_SHADOW, 32'h0, "nomap_src");
      host.wr(1'b0, audio_smi_pkg::OFS_TRAP_EN, 32'h1);
      io_acc(1'b0, 10'h388, 8'h00);
      check("trap_claim", {31'h0, c}, 32'h0);
      check("trap_smi", {31'h0, smi}, 32'h1);
      rr(1'b0, audio_smi_pkg::OFS_TRAP_STAT, 32'h1, "trap_rd");
      rr(1'b0, audio_smi_pkg::OFS_SRC_CLEAR, 32'h1, "trap_clr");
      // fast write pairs: index write absorbed, next trapped write fires
      host.wr(1'b0, audio_smi_pkg::OFS_TRAP_EN, 32'h803);
      for (int k = 0; k < 6; k++) begin
         a = fa[fw[k]];
         io_acc(1'b1, a, 8'(8'h50 + k));
         check("fw_nosmi", {31'h0, smi}, 32'h0);
         rr(1'b0, audio_smi_pkg::OFS_SRC_SHADOW, 32'h0, "fw_src");
         host.rd(1'b0, audio_smi_pkg::OFS_TRAP_STAT, d, v);
         check("fw_a1", {31'h0, d[15]}, {31'h0, a[1]});
         if (!a[0]) begin
            check("fw_even", {24'h0, d[31:24]}, 32'(8'h50 + k));
         end else begin
            check("fw_oddix", {24'h0, d[23:16]}, 32'(8'h50 + k));
         end
         io_acc(1'b1, 10'h389, 8'(8'h70 + k));
         check("fw_smi", {31'h0, smi}, 32'h1);
         host.rd(1'b0, audio_smi_pkg::OFS_TRAP_STAT, d, v);
         check("fw_odd", {24'h0, d[23:16]}, 32'(8'h70 + k));
         check("fw_rw", {30'h0, d[14], d[0]}, 32'h3);
         rr(1'b0, audio_smi_pkg::OFS_SRC_CLEAR, 32'h1, "fw_clr");
      end
      // 389h is no fast-write address: a lone write there traps
      io_acc(1'b1, 10'h389, 8'h11);
      check("fw_389", {31'h0, smi}, 32'h1);
      rr(1'b0, audio_smi_pkg::OFS_SRC_CLEAR, 32'h1, "fw_389clr");
      close_out();
   end
endmodule
